/* File: hdl/lcdtim_pkg.sv */
// lcdtim_pkg: constants for the lcd matrix drive timing block
package lcdtim_pkg;
  // shift ratio strap codes
  localparam logic [1:0] RATIO_4 = 2'h0;
  localparam logic [1:0] RATIO_8 = 2'h1;
  localparam logic [1:0] RATIO_16 = 2'h2;
  localparam logic [1:0] RATIO_RSVD = 2'h3;
  localparam int DIV_4 = 4;
  localparam int DIV_8 = 8;
  localparam int DIV_16 = 16;
  // nibbles per column driver before the enable chain advances
  localparam int CHAIN_PULSES = 16;
  localparam int CHAIN_W = 4;
  localparam logic [3:0] CHAIN_LAST = 4'hf;
  // default panel geometry
  localparam int DEF_NIBBLES = 80;
  localparam int DEF_LINES = 64;
  localparam int DEF_BIAS_LINES = 16;
  // blank cycles reserved for the latch pulse slot
  localparam int LATCH_SLOTS = 2;
  typedef enum logic [1:0] {
    LCDTIM_ST_OFF,
    LCDTIM_ST_RUN,
    LCDTIM_ST_STOP
  } lcdtim_state_e;
endpackage : lcdtim_pkg

/* File: hdl/lcdtim_div.sv */
// lcdtim_div: strap-selected divider giving shift clock phase ticks
module lcdtim_div (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // synchronised strap
  input wire logic [1:0] ratio,
  // one-cycle ticks: rise at start of period, fall at half period
  output logic rise_tick,
  output logic fall_tick
);
  logic [3:0] cnt_q;
  logic [3:0] last;
  logic [3:0] half;

  // reserved strap code falls back to the slowest ratio
  always_comb begin
    case (ratio)
      lcdtim_pkg::RATIO_4: last = 4'(lcdtim_pkg::DIV_4 - 1);
      lcdtim_pkg::RATIO_8: last = 4'(lcdtim_pkg::DIV_8 - 1);
      default: last = 4'(lcdtim_pkg::DIV_16 - 1);
    endcase
    half = last >> 1;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 4'h0;
    end else if (cnt_q >= last) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  assign rise_tick = (cnt_q == 4'h0);
  assign fall_tick = (cnt_q == (half + 4'h1));
endmodule // lcdtim_div

/* File: hdl/lcdtim_top.sv */
// lcdtim_top: passive lcd matrix column and row drive timing
// Function
// - column pixel data is driven as a 4-bit parallel word.
// - data nibble stays stable around each falling edge of the shift clock.
// - enable chain clock falls every sixteenth shift pulse to advance drivers.
// - exactly one falling-edge line latch pulse per display line.
// - backplane bias toggles with a period set by configuration.
// - row shift clock falling edge captures the frame pulse into row drivers.
// - frame pulse is asserted only during the last line of each frame.
// - shift clock period is 4, 8 or 16 input clocks by strap; code 3 reserved.
module lcdtim_top #(
  parameter int NIBBLES = lcdtim_pkg::DEF_NIBBLES,
  parameter int LINES = lcdtim_pkg::DEF_LINES
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // configuration
  input wire logic [1:0] shift_ratio_strap,
  input wire logic [7:0] bias_lines,
  input wire logic display_on,
  input wire logic power_save,
  // pixel source
  input wire logic [3:0] pixel_nibble,
  output logic pixel_take,
  // panel column side
  output logic [3:0] column_data,
  output logic column_shift_clock,
  output logic column_enable_chain_clock,
  output logic line_latch_pulse,
  // panel row side
  output logic backplane_bias,
  output logic row_shift_clock,
  output logic frame_pulse,
  output logic row_drive_enable
);
  localparam int NW = $clog2(NIBBLES + lcdtim_pkg::LATCH_SLOTS + 1);
  localparam int LW = $clog2(LINES + 1);

  if (NIBBLES < 1 || LINES < 2) begin : g_bad_geometry
    $error("lcdtim_top: NIBBLES and LINES too small");
  end

  //////////////////////////////////////////////////////////////////////////////
  // strap synchroniser: pins are outside the clock domain
  logic [1:0] strap_s1_q;
  logic [1:0] strap_s2_q;
  // no reset: a reset value would fake a ratio change at release
  always_ff @(posedge clk) begin
    strap_s1_q <= shift_ratio_strap;
    strap_s2_q <= strap_s1_q;
  end

  logic rise_tick;
  logic fall_tick;
  lcdtim_div u_div (
    .clk(clk),
    .nrst(nrst),
    .ratio(strap_s2_q),
    .rise_tick(rise_tick),
    .fall_tick(fall_tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // line and frame position
  logic [NW-1:0] slot_q;
  logic [LW-1:0] line_q;
  logic [7:0] bias_cnt_q;
  logic [3:0] chain_q;
  logic line_end;
  logic frame_end;
  logic in_data;

  assign in_data = (slot_q < NW'(NIBBLES));
  assign line_end = rise_tick && (slot_q == NW'(NIBBLES + lcdtim_pkg::LATCH_SLOTS - 1));
  assign frame_end = line_end && (line_q == LW'(LINES - 1));

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      slot_q <= '0;
    end else if (line_end) begin
      slot_q <= '0;
    end else if (rise_tick) begin
      slot_q <= slot_q + NW'(1);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      line_q <= '0;
    end else if (frame_end) begin
      line_q <= '0;
    end else if (line_end) begin
      line_q <= line_q + LW'(1);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // column side
  // data changes on the rising phase, panel samples on the falling phase
  assign pixel_take = rise_tick && in_data;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      column_data <= 4'h0;
    end else if (pixel_take) begin
      column_data <= pixel_nibble;
    end
  end

  // gated shift clock only toggles over data slots, idle low in latch slots
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      column_shift_clock <= 1'b0;
    end else if (rise_tick) begin
      column_shift_clock <= in_data;
    end else if (fall_tick) begin
      column_shift_clock <= 1'b0;
    end
  end

  // chain clock: high on the 16th nibble of each driver, falls after it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      chain_q <= 4'h0;
      column_enable_chain_clock <= 1'b0;
    end else if (rise_tick) begin
      chain_q <= in_data ? chain_q + 4'h1 : 4'h0;
      column_enable_chain_clock <= in_data && (chain_q == lcdtim_pkg::CHAIN_LAST);
    end
  end

  // latch pulse high in the first blank slot, falls at the second
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      line_latch_pulse <= 1'b0;
    end else if (rise_tick) begin
      line_latch_pulse <= (slot_q == NW'(NIBBLES));
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // row side
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      row_shift_clock <= 1'b0;
    end else if (rise_tick) begin
      row_shift_clock <= (slot_q == NW'(NIBBLES));
    end else if (fall_tick) begin
      // falls mid latch slot, clear of the frame pulse change at line end
      row_shift_clock <= 1'b0;
    end
  end

  // asserted across the whole last line so the row clock fall samples it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      frame_pulse <= 1'b0;
    end else if (line_end) begin
      frame_pulse <= (line_q == LW'(LINES - 2));
    end
  end

  // bias toggles every bias_lines lines; zero treated as one
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bias_cnt_q <= 8'h0;
      backplane_bias <= 1'b0;
    end else if (line_end) begin
      if (bias_cnt_q + 8'h1 >= bias_lines) begin
        bias_cnt_q <= 8'h0;
        backplane_bias <= ~backplane_bias;
      end else begin
        bias_cnt_q <= bias_cnt_q + 8'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // row enable control
  lcdtim_pkg::lcdtim_state_e st_q;
  logic save_seen_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= lcdtim_pkg::LCDTIM_ST_OFF;
      save_seen_q <= 1'b0;
    end else begin
      case (st_q)
        lcdtim_pkg::LCDTIM_ST_OFF: begin
          if (display_on && !power_save) begin
            st_q <= lcdtim_pkg::LCDTIM_ST_RUN;
          end
        end
        lcdtim_pkg::LCDTIM_ST_RUN: begin
          if (power_save) begin
            st_q <= lcdtim_pkg::LCDTIM_ST_STOP;
          end
        end
        lcdtim_pkg::LCDTIM_ST_STOP: begin
          // first frame end only arms, second drops: one to two frames
          if (frame_end) begin
            if (save_seen_q) begin
              st_q <= lcdtim_pkg::LCDTIM_ST_OFF;
              save_seen_q <= 1'b0;
            end else begin
              save_seen_q <= 1'b1;
            end
          end
        end
        default: st_q <= lcdtim_pkg::LCDTIM_ST_OFF;
      endcase
    end
  end

  // registered so a state change cannot glitch the row supply enable
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      row_drive_enable <= 1'b0;
    end else begin
      row_drive_enable <= (st_q != lcdtim_pkg::LCDTIM_ST_OFF);
    end
  end
endmodule // lcdtim_top

/* File: dv/lcdtim_monitor.sv */
// lcdtim_monitor: port-level timing checks for lcdtim_top
module lcdtim_mon #(parameter int NIBBLES = 32, parameter int LINES = 4) (
  // clock, reset, configuration, pixel source
  input wire logic clk,
  input wire logic nrst,
  input wire logic [1:0] shift_ratio_strap,
  input wire logic display_on,
  input wire logic power_save,
  input wire logic [3:0] pixel_nibble,
  input wire logic pixel_take,
  // panel
  input wire logic [3:0] column_data,
  input wire logic column_shift_clock,
  input wire logic column_enable_chain_clock,
  input wire logic line_latch_pulse,
  input wire logic row_drive_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] hi_q;
  logic [4:0] tk_q;
  logic [3:0] half;
  assign half = shift_ratio_strap == lcdtim_pkg::RATIO_4 ? 4'h2 :
    shift_ratio_strap == lcdtim_pkg::RATIO_8 ? 4'h4 : 4'h8;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hi_q <= 4'h0;
      tk_q <= 5'h0;
    end else begin
      hi_q <= column_shift_clock ? hi_q + 4'h1 : 4'h0;
      tk_q <= $rose(column_enable_chain_clock) ? 5'h0 : tk_q + 5'(pixel_take);
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  AST_DATA_TAKEN: assert property (pixel_take |=> column_data == $past(pixel_nibble))
    else $error("column data differs from taken nibble");
  AST_SHIFT_RISE: assert property (pixel_take |=> $rose(column_shift_clock))
    else $error("shift clock did not rise with new data");
  AST_DATA_STABLE: assert property ($fell(column_shift_clock) |-> $stable(column_data) ##1 $stable(column_data))
    else $error("data moved around shift fall");
  AST_HALF_PERIOD: assert property ($fell(column_shift_clock) |-> hi_q == half)
    else $error("shift clock high time wrong");
  AST_CHAIN_16: assert property ($rose(column_enable_chain_clock) |-> tk_q == 5'h10)
    else $error("chain clock not after 16 nibbles");
  AST_LATCH_QUIET: assert property (line_latch_pulse |-> !column_shift_clock)
    else $error("shift clock runs in latch slot");
  AST_ENABLE_ON: assert property ($rose(row_drive_enable) |-> $past(display_on))
    else $error("row enable without display on");
  AST_DROP_SAVE: assert property ($fell(row_drive_enable) |-> power_save)
    else $error("row enable dropped without power save");
  cover property ($rose(column_enable_chain_clock));
  cover property ($fell(line_latch_pulse));
  cover property ($fell(row_drive_enable));
endmodule // lcdtim_mon

/* File: dv/lcdtim_panel.sv */
// lcdtim_panel: column and row driver chip model
module lcdtim_panel #(parameter int LINES = 4) (
  // panel pins
  input wire logic [3:0] column_data,
  input wire logic column_shift_clock,
  input wire logic line_latch_pulse,
  input wire logic row_shift_clock,
  input wire logic frame_pulse,
  // observed driver state
  output logic [3:0] cap_data,
  output logic [15:0] line_caps,
  output logic [LINES-1:0] row_sr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt = 16'h0;
  logic [15:0] base = 16'h0;
  always @(negedge column_shift_clock) begin
    cap_data <= column_data;
    cnt <= cnt + 16'h1;
  end
  always @(negedge line_latch_pulse) begin
    line_caps <= cnt - base;
    base <= cnt;
  end
  always @(negedge row_shift_clock) row_sr <= {row_sr[LINES-2:0], frame_pulse};
endmodule // lcdtim_panel

/* File: dv/tb.sv */
// tb: self-checking bench for lcdtim_top with a panel model
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NIB = 32;
  localparam int LIN = 4;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] shift_ratio_strap = 2'h0;
  logic [7:0] bias_lines = 8'h02;
  logic display_on = 1'b0;
  logic power_save = 1'b0;
  logic [3:0] pixel_nibble = 4'h0;
  logic [3:0] last_q = 4'h0;
  logic [3:0] column_data, cap_data;
  logic [15:0] line_caps;
  logic [LIN-1:0] row_sr;
  logic pixel_take, column_shift_clock, column_enable_chain_clock, line_latch_pulse;
  logic backplane_bias, row_shift_clock, frame_pulse, row_drive_enable, pb, pf;
  int n_errors = 0;
  int samples_checked = 0;
  int ntog = 0;
  int nfr = 0;
  int nff = 0;
  lcdtim_top #(.NIBBLES(NIB), .LINES(LIN)) i_lcdtim_top (.*);
  lcdtim_panel #(.LINES(LIN)) i_lcdtim_panel (.*);
  always #5 clk = ~clk;
  // nibble held while offered, next one only after it was taken
  always @(negedge clk) begin
    if (pixel_take) last_q <= pixel_nibble;
    else pixel_nibble <= last_q + 4'h3;
    pb <= backplane_bias;
    pf <= frame_pulse;
    if (backplane_bias !== pb) ntog++;
    if (frame_pulse && !pf) nfr++;
    if (!frame_pulse && pf) nff++;
  end
  ////////////////////////////////////////
  task automatic chk(input bit ok, input string msg);
    samples_checked++;
    if (!ok) begin
      n_errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic next_line(output int cyc);
    logic pl;
    cyc = 0;
    do begin
      pl = line_latch_pulse;
      @(negedge clk);
      cyc++;
    end while (!(pl === 1'b1 && line_latch_pulse === 1'b0) && cyc < 9000);
    if (cyc >= 9000) chk(1'b0, "no line latch pulse");
  endtask
  task automatic restart(input logic [1:0] s);
    nrst = 1'b0;
    display_on = 1'b0;
    power_save = 1'b0;
    shift_ratio_strap = s;
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    repeat (5) @(negedge clk);
    chk(row_drive_enable === 1'b0, "row enable before display on");
    display_on = 1'b1;
  endtask
  task automatic t_ratio(input logic [1:0] s, input int div);
    int cyc;
    restart(s);
    next_line(cyc);
    next_line(cyc);
    chk(cyc == (NIB + 2) * div, "line period");
    chk(line_caps === 16'(NIB), "nibbles per line");
    chk(cap_data === last_q, "captured nibble");
    $display("test ratio %0d done", div);
  endtask
  task automatic t_frame();
    int cyc, t0, f0;
    restart(lcdtim_pkg::RATIO_4);
    repeat (LIN) next_line(cyc);
    // toggle counter updates in the same negedge; let it settle first
    @(negedge clk);
    t0 = ntog;
    f0 = nfr;
    repeat (LIN) next_line(cyc);
    @(negedge clk);
    chk(nfr - f0 == 1, "frame pulses per frame");
    chk(ntog - t0 == LIN / 2, "bias toggles");
    chk($countones(row_sr) == 1 && !$isunknown(row_sr), "row scan");
    bias_lines = 8'h01;
    t0 = ntog;
    repeat (LIN) next_line(cyc);
    @(negedge clk);
    chk(ntog - t0 == LIN, "bias toggles every line");
    $display("test frame done");
  endtask
  task automatic t_power();
    int cyc, f0;
    restart(lcdtim_pkg::RATIO_4);
    next_line(cyc);
    chk(row_drive_enable === 1'b1, "row enable while driving");
    power_save = 1'b1;
    f0 = nff;
    cyc = 0;
    while (row_drive_enable === 1'b1 && cyc < 2000) begin
      @(negedge clk);
      cyc++;
    end
    @(negedge clk);
    chk(row_drive_enable === 1'b0 && nff - f0 inside {[1:2]}, "power save shutdown");
    $display("test power save done");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    t_ratio(lcdtim_pkg::RATIO_4, lcdtim_pkg::DIV_4);
    t_ratio(lcdtim_pkg::RATIO_8, lcdtim_pkg::DIV_8);
    t_ratio(lcdtim_pkg::RATIO_16, lcdtim_pkg::DIV_16);
    t_ratio(lcdtim_pkg::RATIO_RSVD, lcdtim_pkg::DIV_16);
    t_frame();
    t_power();
    conclude();
  end
  initial begin
    #400us;
    n_errors++;
    $display("mismatch at %0t: timeout", $time);
    conclude();
  end
endmodule // tb
bind lcdtim_top lcdtim_mon #(.NIBBLES(NIBBLES), .LINES(LINES)) i_lcdtim_mon (.*);
